// ### inc/meac_pkg.sv
// Constants and types of the acquisition control block.
// Assumes a single ref_clk domain and a plain register port.
package meac_pkg;

  // Geometry
  localparam int unsigned CH_NUM = 4;
  localparam int unsigned SAMP_W = 12;
  localparam int unsigned LOC_W = 19;
  localparam int unsigned BUF_W = 10;
  localparam int unsigned TTT_CNT_W = 31;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ORG = 8'h08;
  localparam logic [7:0] REG_CUST = 8'h0c;
  localparam logic [7:0] REG_POST = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_EVCNT = 8'h18;
  localparam logic [7:0] REG_NSMAX = 8'h1c;
  localparam logic [7:0] REG_DATA = 8'h20;

  // Control fields
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_RUN_BIT = 2;
  localparam int unsigned CTRL_CNTALL_BIT = 3;
  localparam int unsigned CTRL_EXTREF_BIT = 4;
  localparam int unsigned CTRL_OVL_BIT = 5;
  localparam int unsigned CTRL_PACK_BIT = 6;

  // Status fields
  localparam int unsigned STAT_EXTREF_BIT = 0;
  localparam int unsigned STAT_RUN_BIT = 1;
  localparam int unsigned STAT_FULL_BIT = 2;
  localparam int unsigned STAT_DRDY_BIT = 3;

  // Reset values and organisation code limit
  localparam logic [3:0] ORG_RST = 4'h0;
  localparam logic [3:0] ORG_MAX = 4'ha;
  localparam logic [31:0] POST_RST = 32'h0000_0010;
  localparam logic [31:0] MASK_RST = 32'h0000_000f;

  // Header layout
  localparam logic [3:0] HDR_TAG = 4'ha;
  localparam int unsigned HDR_WORDS = 4;
  localparam int unsigned HDR_FMT_BIT = 24;
  localparam logic FMT_NORMAL = 1'b0;

  typedef struct packed {
    logic packed_mode;
    logic ovl_en;
    logic ext_ref;
    logic cnt_all;
    logic run;
    logic gpi_mode;
  } meac_ctrl_s;

  localparam meac_ctrl_s CTRL_RST = '0;

  typedef enum {RD_HDR, RD_DATA} meac_rd_e;

endpackage

// ### rtl/meac_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous level input and the ref_clk domain.
module meac_sync
  import meac_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Level in and out
  input wire logic din,
  output logic dout
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Chain
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Output moves once stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dout <= 1'b0;
    end else if (s2_q == s3_q) begin
      dout <= s3_q;
    end
  end

endmodule

// ### rtl/meac_top.sv
// Run control, trigger stamping, multi-event buffer and event readout.
// Assumes samples arrive on ref_clk and pins are asynchronous.
// Contract
// - Bus and acquisition logic share one ref_clk in this build.
// - Internal reference selected after reset; external only by register.
// - Trigger logic works at half the sample rate.
// - Register mode: run bit starts and stops acquisition.
// - Input mode: input pin high runs, low stops acquisition.
// - Accepted trigger latches 32-bit time counter; its LSB is zero.
// - Time counter is 31 bits plus overflow, cleared at run start.
// - Accepted trigger counts, completes window, freezes buffer, moves on.
// - Organisation code n splits memory into 2^n buffers.
// - Software chooses to accept or reject overlapping triggers.
// - Overlap accepted: current buffer closes, storage moves to next.
// - Refuse when idle, full, short of pre-trigger, or forbidden overlap.
// - Refused trigger keeps current buffer active and written.
// - Event counter counts all triggers or only accepted ones.
// - A location holds two samples; custom size zero means maximum.
// - Custom size N1 gives 2 N1 samples; N1 above buffer size is clamped.
// - Per-buffer sample maximum is 512K or 640K over buffer count.
// - Event is four header words then 32-bit data words.
// - Header holds size, format bit 24, mask, counter and time.
// - Channels outside the mask are skipped in readout.
// - Each data word carries two samples.
module meac_top
  import meac_pkg::*;
#(
  parameter int unsigned CHN = CH_NUM,
  parameter int unsigned LOCW = LOC_W,
  parameter int unsigned BUFW = BUF_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pins and samples
  input wire logic gpi_pin,
  input wire logic trig_pin,
  input wire logic [CHN*SAMP_W-1:0] samp_data,
  // Status
  output logic ref_sel_ext,
  output logic running,
  output logic busy,
  output logic data_ready
);

  localparam int unsigned LW = 2 * SAMP_W;
  localparam int unsigned MW = CHN * LW;
  localparam int unsigned CHW = $clog2(CHN + 1);
  localparam int unsigned NB = 1 << BUFW;

  function automatic logic [LOCW-1:0] phys_f(input logic [BUFW-1:0] b,
      input logic [LOCW-1:0] off, input logic [3:0] n);
    logic [LOCW+BUFW-1:0] w;
    w = {{LOCW{1'b0}}, b} << (LOCW - n);
    return w[LOCW-1:0] | off;
  endfunction

  function automatic logic [CHW-1:0] next_ch_f(input logic [CHN-1:0] m,
      input logic [CHW-1:0] from);
    logic [CHW-1:0] r;
    r = CHW'(CHN);
    for (int i = CHN - 1; i >= 0; i--) begin
      if (m[i] && CHW'(i) >= from) begin
        r = CHW'(i);
      end
    end
    return r;
  endfunction

  meac_ctrl_s ctrl_q;
  logic [3:0] org_q;
  logic [LOCW:0] cust_q;
  logic [LOCW:0] post_q;
  logic [CHN-1:0] mask_q;

  logic gpi_s;
  logic trig_s;
  logic trig_prev_q;
  logic trig_pend_q;
  logic run_q;
  logic phase_q;
  logic [31:0] ttt_q;
  logic [23:0] evc_q;
  logic [31:0] act_ttt_q;
  logic [23:0] act_evc_q;
  logic [BUFW-1:0] wbuf_q;
  logic [BUFW-1:0] rbuf_q;
  logic [LOCW-1:0] woff_q;
  logic [LOCW:0] fill_q;
  logic [LOCW:0] postcnt_q;
  logic in_post_q;
  logic [BUFW:0] frozen_q;
  logic [CHN*SAMP_W-1:0] pair_q;

  meac_rd_e rd_st_q;
  logic [1:0] hdr_q;
  logic [CHW-1:0] ch_q;
  logic [LOCW:0] lc_q;

  logic [MW-1:0] mem [0:(1<<LOCW)-1];
  logic [LOCW-1:0] meta_end [0:NB-1];
  logic [LOCW:0] meta_len [0:NB-1];
  logic [31:0] meta_ttt [0:NB-1];
  logic [23:0] meta_evc [0:NB-1];

  // Two-stage-agree input synchronisers
  meac_sync u_gpi_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(gpi_pin),
    .dout(gpi_s)
  );

  meac_sync u_trig_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(trig_pin),
    .dout(trig_s)
  );

  // Buffer geometry
  logic [LOCW:0] bsize;
  logic [LOCW-1:0] off_mask;
  logic [BUFW:0] nbuf;
  logic [LOCW:0] evlen;
  logic [LOCW:0] postc;
  logic [LOCW:0] pre_need;
  logic [31:0] ns_max;

  always_comb begin
    bsize = {1'b1, {LOCW{1'b0}}} >> org_q;
    off_mask = LOCW'(bsize - 1'b1);
    nbuf = {{BUFW{1'b0}}, 1'b1} << org_q;
    evlen = (cust_q == '0 || cust_q > bsize) ? bsize : cust_q;
    postc = (post_q > evlen) ? evlen : post_q;
    pre_need = evlen - postc;
    ns_max = ctrl_q.packed_mode ?
      (32'(5 << LOCW) >> 2) >> org_q : 32'(1 << LOCW) >> org_q;
  end

  // Trigger qualification
  logic run_lvl;
  logic start;
  logic trig_edge;
  logic tev;
  logic tcheck;
  logic full;
  logic refuse;
  logic accept;
  logic stor;
  logic post_done;
  logic frz_now;
  logic freeze;
  logic [LOCW-1:0] woff_inc;
  logic [LOCW:0] fill_inc;
  logic [LOCW:0] frz_len;
  logic rel;

  always_comb begin
    run_lvl = ctrl_q.gpi_mode ? gpi_s : ctrl_q.run;
    start = run_lvl && !run_q;
    trig_edge = trig_s && !trig_prev_q;
    tev = trig_pend_q || trig_edge;
    tcheck = tev && !phase_q;
    full = (frozen_q == nbuf);
    refuse = !run_q || full ||
      (in_post_q && (!ctrl_q.ovl_en || frozen_q + 1'b1 >= nbuf)) ||
      (!in_post_q && fill_q < pre_need);
    accept = tcheck && !refuse;
    stor = run_q && phase_q && !full;
    post_done = in_post_q && stor && postcnt_q == 1;
    frz_now = accept && (in_post_q || postc == '0);
    freeze = frz_now || post_done;
    woff_inc = (woff_q + 1'b1) & off_mask;
    fill_inc = (fill_q == bsize) ? fill_q : fill_q + 1'b1;
    frz_len = post_done ? fill_inc : fill_q;
    if (frz_len > evlen) begin
      frz_len = evlen;
    end
  end

  // Run state, time counter and phase
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      phase_q <= 1'b0;
      ttt_q <= '0;
    end else begin
      run_q <= run_lvl;
      if (start) begin
        phase_q <= 1'b0;
        ttt_q <= '0;
      end else if (run_q) begin
        phase_q <= !phase_q;
        ttt_q[TTT_CNT_W-1:0] <= ttt_q[TTT_CNT_W-1:0] + 1'b1;
        ttt_q[TTT_CNT_W] <= ttt_q[TTT_CNT_W] | (&ttt_q[TTT_CNT_W-1:0]);
      end else begin
        phase_q <= 1'b0;
      end
    end
  end

  // Trigger pending flag; set on the odd phase, cleared in every check cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trig_prev_q <= 1'b0;
      trig_pend_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_s;
      trig_pend_q <= phase_q ? tev : 1'b0;
    end
  end

  // Event counter and stamp of the open event
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      evc_q <= '0;
      act_ttt_q <= '0;
      act_evc_q <= '0;
    end else begin
      if (start) begin
        evc_q <= '0;
      end else if (accept || (ctrl_q.cnt_all && tcheck)) begin
        evc_q <= evc_q + 1'b1;
      end
      if (accept) begin
        act_ttt_q <= ttt_q;
        act_evc_q <= evc_q + 1'b1;
      end
    end
  end

  // Write pointer, fill level and post-trigger window
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wbuf_q <= '0;
      woff_q <= '0;
      fill_q <= '0;
      postcnt_q <= '0;
      in_post_q <= 1'b0;
    end else if (start) begin
      woff_q <= '0;
      fill_q <= '0;
      in_post_q <= 1'b0;
    end else begin
      if (freeze) begin
        wbuf_q <= BUFW'((wbuf_q + 1'b1) & (nbuf - 1'b1));
        woff_q <= '0;
        fill_q <= '0;
      end else if (stor) begin
        woff_q <= woff_inc;
        fill_q <= fill_inc;
      end
      if (accept && postc != '0) begin
        in_post_q <= 1'b1;
        postcnt_q <= postc;
      end else if (post_done || (accept && postc == '0)) begin
        in_post_q <= 1'b0;
      end else if (in_post_q && stor) begin
        postcnt_q <= postcnt_q - 1'b1;
      end
    end
  end

  // Sample pairing and storage, two samples per location
  logic [MW-1:0] wr_word;

  always_comb begin
    wr_word = '0;
    for (int c = 0; c < CHN; c++) begin
      wr_word[c*LW +: LW] = {samp_data[c*SAMP_W +: SAMP_W],
        pair_q[c*SAMP_W +: SAMP_W]};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pair_q <= '0;
    end else if (!phase_q) begin
      pair_q <= samp_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (stor) begin
      mem[phys_f(wbuf_q, woff_q, org_q)] <= wr_word;
    end
  end

  // Buffer descriptors written at freeze
  always_ff @(posedge ref_clk) begin
    if (freeze) begin
      meta_end[wbuf_q] <= post_done ? woff_inc : woff_q;
      meta_len[wbuf_q] <= frz_len;
      meta_ttt[wbuf_q] <= (accept && !in_post_q) ? ttt_q : act_ttt_q;
      meta_evc[wbuf_q] <= (accept && !in_post_q) ? evc_q + 1'b1 : act_evc_q;
    end
  end

  // Frozen queue
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frozen_q <= '0;
      rbuf_q <= '0;
    end else begin
      frozen_q <= frozen_q + BUFW'(freeze) - BUFW'(rel);
      if (rel) begin
        rbuf_q <= BUFW'((rbuf_q + 1'b1) & (nbuf - 1'b1));
      end
    end
  end

  // Readout word assembly
  logic [LOCW:0] r_len;
  logic [LOCW-1:0] r_off;
  logic [MW-1:0] r_loc;
  logic [LW-1:0] r_cw;
  logic [CHW-1:0] first_ch;
  logic [CHW-1:0] nxt_ch;
  logic [31:0] ev_size;
  logic [31:0] cur_word;
  logic pop;
  logic [CHW-1:0] ch_sel;

  always_comb begin
    r_len = meta_len[rbuf_q];
    r_off = (meta_end[rbuf_q] - r_len[LOCW-1:0] + lc_q[LOCW-1:0]) & off_mask;
    r_loc = mem[phys_f(rbuf_q, r_off, org_q)];
    ch_sel = (ch_q < CHW'(CHN)) ? ch_q : '0;
    r_cw = r_loc[ch_sel*LW +: LW];
    first_ch = next_ch_f(mask_q, '0);
    nxt_ch = next_ch_f(mask_q, ch_q + 1'b1);
    ev_size = 32'(HDR_WORDS) + 32'($countones(mask_q)) * 32'(r_len);
    cur_word = '0;
    if (rd_st_q == RD_DATA) begin
      cur_word = {4'h0, r_cw[LW-1:SAMP_W], 4'h0, r_cw[SAMP_W-1:0]};
    end else begin
      unique case (hdr_q)
        2'h0: cur_word = {HDR_TAG, ev_size[27:0]};
        2'h1: begin
          cur_word = {{(32-CHN){1'b0}}, mask_q};
          cur_word[HDR_FMT_BIT] = FMT_NORMAL;
        end
        2'h2: cur_word = {8'h00, meta_evc[rbuf_q]};
        2'h3: cur_word = meta_ttt[rbuf_q];
      endcase
    end
    pop = reg_rd && reg_addr == REG_DATA && frozen_q != '0;
    rel = pop && ((rd_st_q == RD_HDR && hdr_q == 2'h3 &&
      (first_ch == CHW'(CHN) || r_len == '0)) ||
      (rd_st_q == RD_DATA && lc_q + 1'b1 == r_len &&
      nxt_ch == CHW'(CHN)));
  end

  // Readout sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_st_q <= RD_HDR;
      hdr_q <= '0;
      ch_q <= '0;
      lc_q <= '0;
    end else if (rel) begin
      rd_st_q <= RD_HDR;
      hdr_q <= '0;
    end else if (pop) begin
      unique case (rd_st_q)
        RD_HDR: begin
          if (hdr_q != 2'h3) begin
            hdr_q <= hdr_q + 1'b1;
          end else begin
            rd_st_q <= RD_DATA;
            ch_q <= first_ch;
            lc_q <= '0;
          end
        end
        RD_DATA: begin
          if (lc_q + 1'b1 == r_len) begin
            ch_q <= nxt_ch;
            lc_q <= '0;
          end else begin
            lc_q <= lc_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Register writes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      org_q <= ORG_RST;
      cust_q <= '0;
      post_q <= (LOCW+1)'(POST_RST);
      mask_q <= CHN'(MASK_RST);
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: begin
          ctrl_q.gpi_mode <= reg_wdata[CTRL_MODE_BIT];
          ctrl_q.run <= reg_wdata[CTRL_RUN_BIT];
          ctrl_q.cnt_all <= reg_wdata[CTRL_CNTALL_BIT];
          ctrl_q.ext_ref <= reg_wdata[CTRL_EXTREF_BIT];
          ctrl_q.ovl_en <= reg_wdata[CTRL_OVL_BIT];
          ctrl_q.packed_mode <= reg_wdata[CTRL_PACK_BIT];
        end
        REG_ORG: begin
          org_q <= (reg_wdata[3:0] > ORG_MAX) ? ORG_MAX : reg_wdata[3:0];
        end
        REG_CUST: cust_q <= reg_wdata[LOCW:0];
        REG_POST: post_q <= reg_wdata[LOCW:0];
        REG_MASK: mask_q <= reg_wdata[CHN-1:0];
        default: ;
      endcase
    end
  end

  // Register reads, data valid only in the cycle after the strobe
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      REG_CTRL: begin
        rd_mux[CTRL_MODE_BIT] = ctrl_q.gpi_mode;
        rd_mux[CTRL_RUN_BIT] = ctrl_q.run;
        rd_mux[CTRL_CNTALL_BIT] = ctrl_q.cnt_all;
        rd_mux[CTRL_EXTREF_BIT] = ctrl_q.ext_ref;
        rd_mux[CTRL_OVL_BIT] = ctrl_q.ovl_en;
        rd_mux[CTRL_PACK_BIT] = ctrl_q.packed_mode;
      end
      REG_STAT: begin
        rd_mux[STAT_EXTREF_BIT] = ctrl_q.ext_ref;
        rd_mux[STAT_RUN_BIT] = run_q;
        rd_mux[STAT_FULL_BIT] = full;
        rd_mux[STAT_DRDY_BIT] = frozen_q != '0;
      end
      REG_ORG: rd_mux = {28'h0, org_q};
      REG_CUST: rd_mux = 32'(cust_q);
      REG_POST: rd_mux = 32'(post_q);
      REG_MASK: rd_mux = 32'(mask_q);
      REG_EVCNT: rd_mux = {8'h00, evc_q};
      REG_NSMAX: rd_mux = ns_max;
      REG_DATA: rd_mux = (frozen_q != '0) ? cur_word : '0;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  assign ref_sel_ext = ctrl_q.ext_ref;
  assign running = run_q;
  assign busy = full;
  assign data_ready = frozen_q != '0;

  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_TTT_CLR: assert property (start |=> ttt_q == 32'h0)
    else $error("Time counter not cleared at run start");
  AST_TTT_EVEN: assert property (accept |=> act_ttt_q[0] == 1'b0)
    else $error("Latched trigger time is odd");
  AST_HALF_RATE: assert property (accept |=> !tcheck)
    else $error("Trigger checked on two adjacent cycles");
  AST_REF_SEL: assert property ($rose(ref_sel_ext) |->
    $past(reg_wr) && $past(reg_addr) == REG_CTRL)
    else $error("External reference selected without a write");
  AST_REG_RUN: assert property (
    (!ctrl_q.gpi_mode && ctrl_q.run) [*2] |-> running)
    else $error("Run bit did not start acquisition");
  AST_GPI_RUN: assert property (
    (ctrl_q.gpi_mode && !gpi_s) [*2] |-> !running)
    else $error("Input low did not stop acquisition");
  AST_EVCNT: assert property (accept |=>
    evc_q == $past(evc_q) + 24'h1)
    else $error("Event counter not advanced on accept");
  AST_FULL_STALL: assert property ((full && !rel) |=>
    !accept && $stable(woff_q))
    else $error("Activity while memory full");
  AST_REFUSE_KEEP: assert property ((tcheck && !accept) |=>
    wbuf_q == $past(wbuf_q) || $past(post_done))
    else $error("Refused trigger changed the active buffer");
  AST_RELEASE: assert property ((rel && !freeze) |=>
    frozen_q == $past(frozen_q) - 1'b1)
    else $error("Read buffer not released");

endmodule

// ### sim/meac_host.sv
// Host readout and front-end model: register master, trigger, run pin.
// Assumes the block samples every input on rising ref_clk edges.
module meac_host
  import meac_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pins and samples
  output logic gpi_pin,
  output logic trig_pin,
  output logic [CH_NUM*SAMP_W-1:0] samp_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    gpi_pin = 1'b0;
    trig_pin = 1'b0;
    samp_data = {12'habc, 12'h789, 12'h456, 12'h123};
  end

  // One-cycle write; idle lines show the inverse afterwards
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask

  // One-cycle read; data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // Trigger edge held long enough for the input filter
  task automatic trig();
    @(posedge ref_clk);
    trig_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    trig_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // Run-control level
  task automatic set_gpi(input logic v);
    @(posedge ref_clk);
    gpi_pin <= v;
  endtask
endmodule

// ### sim/meac_top_tb.sv
// Self-checking bench of the acquisition control block.
// Assumes the host model carries all register traffic and pin activity.
module meac_top_tb
  import meac_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned LW = 8;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic gpi_pin;
  logic trig_pin;
  logic [CH_NUM*SAMP_W-1:0] samp_data;
  logic ref_sel_ext;
  logic running;
  logic busy;
  logic data_ready;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] ra [7] = '{REG_STAT, REG_ORG, REG_CUST, REG_POST,
    REG_MASK, REG_EVCNT, 8'h40};
  logic [31:0] re [7] = '{32'h0, 32'h0, 32'h0, POST_RST, MASK_RST,
    32'h0, 32'h0};

  always #2 ref_clk = ~ref_clk;

  meac_top #(.CHN(CH_NUM), .LOCW(LW), .BUFW(BUF_W)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .gpi_pin(gpi_pin), .trig_pin(trig_pin),
    .samp_data(samp_data), .ref_sel_ext(ref_sel_ext),
    .running(running), .busy(busy), .data_ready(data_ready)
  );

  meac_host u_host (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gpi_pin(gpi_pin), .trig_pin(trig_pin), .samp_data(samp_data)
  );

  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    logic [31:0] v;
    u_host.rd(a, v);
    chk(n, e, v);
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_rdy();
    int i;
    i = 0;
    while (data_ready !== 1'b1 && i < 400) begin
      pause(1);
      i++;
    end
    chk("data_ready", 1, data_ready);
  endtask

  // Reads one event of mask 5 (channels 0 and 2) and checks it
  task automatic rd_event(input logic [31:0] cnt, input logic [31:0] tmax,
                          input int esz, input logic rdy);
    logic [31:0] h0;
    logic [31:0] h3;
    int nw;
    u_host.rd(REG_DATA, h0);
    chk("hdr tag", {HDR_TAG, 28'h0}, {h0[31:28], 28'h0});
    if (esz > 0) begin
      chk("size", esz, {4'h0, h0[27:0]});
    end
    rc(REG_DATA, 32'h5, "hdr mask");
    rc(REG_DATA, cnt, "hdr count");
    u_host.rd(REG_DATA, h3);
    chk("time lsb", 0, h3[0]);
    chk("time start", 1, h3 < tmax);
    nw = (int'(h0[27:0]) - 4) / 2;
    if (nw > 64) begin
      nw = 0;
    end
    for (int i = 0; i < 2 * nw; i++) begin
      rc(REG_DATA, (i < nw) ? 32'h0123_0123 : 32'h0789_0789, "data");
    end
    chk("data_ready", rdy, data_ready);
  endtask

  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    pause(1);
    chk("ref_sel_ext", 0, ref_sel_ext);
    u_host.wr(8'h40, 32'hffff_ffff);
    for (int i = 0; i < 7; i++) rc(ra[i], re[i], "reset value");
    u_host.wr(REG_CTRL, 32'h10);
    chk("ref_sel_ext", 1, ref_sel_ext);
    rc(REG_STAT, 32'h1, "stat extref");
    u_host.wr(REG_ORG, 32'hff);
    rc(REG_ORG, 32'ha, "org clamp");
    u_host.wr(REG_ORG, 32'h2);
    rc(REG_NSMAX, 32'h40, "sample max");
    u_host.wr(REG_CTRL, 32'h40);
    rc(REG_NSMAX, 32'h50, "packed max");
    u_host.wr(REG_CTRL, 32'h0);
    u_host.trig();
    rc(REG_EVCNT, 32'h0, "idle trigger");
    u_host.wr(REG_CUST, 32'd31);
    u_host.wr(REG_POST, 32'd4);
    u_host.wr(REG_MASK, 32'h5);
    u_host.wr(REG_CTRL, 32'h0c);
    pause(3);
    chk("running", 1, running);
    u_host.trig();
    rc(REG_EVCNT, 32'h1, "count all");
    chk("data_ready", 0, data_ready);
    pause(100);
    u_host.trig();
    wait_rdy();
    rc(REG_EVCNT, 32'h2, "count all");
    rd_event(32'h2, 32'h400, 66, 1'b0);
    u_host.wr(REG_CTRL, 32'h0);
    pause(3);
    chk("running", 0, running);
    u_host.wr(REG_POST, 32'd20);
    u_host.wr(REG_CTRL, 32'h04);
    pause(100);
    u_host.trig();
    u_host.trig();
    wait_rdy();
    rc(REG_EVCNT, 32'h1, "overlap refused");
    rd_event(32'h1, 32'h400, 66, 1'b0);
    u_host.wr(REG_CTRL, 32'h24);
    pause(100);
    u_host.trig();
    u_host.trig();
    wait_rdy();
    rd_event(32'h2, 32'hffff_ffff, 66, 1'b1);
    wait_rdy();
    rd_event(32'h3, 32'hffff_ffff, 44, 1'b0);
    u_host.wr(REG_CTRL, 32'h1);
    pause(8);
    chk("running", 0, running);
    u_host.set_gpi(1'b1);
    pause(8);
    chk("running", 1, running);
    u_host.set_gpi(1'b0);
    pause(8);
    chk("running", 0, running);
    u_host.wr(REG_CTRL, 32'h0);
    u_host.wr(REG_ORG, 32'h0);
    u_host.wr(REG_CUST, 32'd8);
    u_host.wr(REG_POST, 32'd2);
    u_host.wr(REG_CTRL, 32'h04);
    pause(40);
    u_host.trig();
    wait_rdy();
    chk("busy", 1, busy);
    u_host.trig();
    rc(REG_EVCNT, 32'h1, "full refused");
    rd_event(32'h1, 32'h400, 20, 1'b0);
    chk("busy", 0, busy);
    tally_and_finish();
  end
endmodule
